// [hw/fsc_defines.vh]
// register map, field layout and reset values of the fan speed curve block
`ifndef FSC_DEFINES_VH
`define FSC_DEFINES_VH

// register byte offsets
`define FSC_REG_CTRL 8'h00
`define FSC_REG_SPEED 8'h04
`define FSC_REG_INPUT 8'h08
`define FSC_REG_ONOFF 8'h0c
`define FSC_REG_ALARM 8'h10
`define FSC_REG_STATUS 8'h14

// field positions
`define FSC_CTRL_PWM 0
`define FSC_CTRL_FAILIDLE 1
`define FSC_CTRL_COMMIT 2
`define FSC_ONOFF_EN 16
`define FSC_ALARM_EN 8

// reset values (temperature mode defaults)
`define FSC_RST_FULLSPD 7'h64
`define FSC_RST_IDLESPD 7'h37
`define FSC_RST_OVRSPD 7'h64
`define FSC_RST_FULLIN 8'h28
`define FSC_RST_IDLEIN 8'h23
`define FSC_RST_TRIP 8'h32

// limits and fail-safe inputs
`define FSC_PCT_MAX 7'h64
`define FSC_LOSS_TEMP 8'he7
`define FSC_LOSS_DUTY 8'h00

// bus responses
`define FSC_RESP_OKAY 2'h0
`define FSC_RESP_SLVERR 2'h2

`endif

// [hw/fsc_speed_logic.v]
// fan speed curve, on/off, alarm and fail-safe logic with AXI4-Lite registers
//
// Contract
// - closed override contact forces override speed
// - override speed of zero turns motor off
// - temperature at/above full input gives full speed
// - pwm full input is maximum duty point
// - full input below idle input is rejected
// - temperature at/below idle input gives idle speed
// - pwm idle input is minimum duty point
// - on/off disabled by default, idle runs below
// - enabled on/off switches at on/off thresholds
// - on threshold <= idle input, > off threshold
// - off threshold always strictly below on threshold; checked only on writes that set the on/off enable
// - alarm asserts when input reaches trip threshold
// - alarm forces full speed
// - alarm clears itself when condition removed
// - signal loss with full choice gives full speed
// - idle choice treats loss as -25C or 0%
// - changes act now, commit request saves them
// - hottest of several thermistors is used
// - open sensor input also raises alarm in temperature mode only
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "fsc_defines.vh"

module fsc_speed_logic #(
   parameter NSENSE = 3
) (
   // clock and reset
   input wire clk,
   input wire resetn,
   // AXI4-Lite write address
   input wire [7:0] awaddr,
   input wire awvalid,
   output wire awready,
   // AXI4-Lite write data
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output wire wready,
   // AXI4-Lite write response
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   // AXI4-Lite read address
   input wire [7:0] araddr,
   input wire arvalid,
   output wire arready,
   // AXI4-Lite read data
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready,
   // control input header: signed degrees per sensor, pwm duty percent
   input wire [8*NSENSE-1:0] controlInputHeader,
   input wire [NSENSE-1:0] sensorPresent,
   input wire [6:0] pwmInputTerminal,
   input wire sensorOpen,
   input wire signalLost,
   input wire overrideContactInput,
   // outputs
   output reg [6:0] driveLevel,
   output reg alarmOutput,
   output reg commitReq
);

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   reg pwmMode;
   reg failIdle;
   reg [6:0] fullSpd;
   reg [6:0] idleSpd;
   reg [6:0] ovrSpd;
   reg [7:0] fullIn;
   reg [7:0] idleIn;
   reg [7:0] onIn;
   reg [7:0] offIn;
   reg onOffEn;
   reg [7:0] tripIn;
   reg alarmEn;
   reg motorOn;
   reg [7:0] ctrlValue;

   // ----------------------------------------
   // bus channel holding
   // ----------------------------------------
   reg awHeld;
   reg wHeld;
   reg [7:0] awAddrHold;
   reg [31:0] wDataHold;
   reg [3:0] wStrbHold;

   assign awready = !awHeld && !bvalid;
   assign wready = !wHeld && !bvalid;
   assign arready = !rvalid;

   wire doWrite = awHeld && wHeld && !bvalid;

   // current word at write address, merged with strobed bytes
   reg [31:0] oldWord;
   always @* begin
      case (awAddrHold)
         `FSC_REG_CTRL: oldWord = {30'h0, failIdle, pwmMode};
         `FSC_REG_SPEED: oldWord = {9'h0, ovrSpd, 1'b0, idleSpd, 1'b0, fullSpd};
         `FSC_REG_INPUT: oldWord = {16'h0, idleIn, fullIn};
         `FSC_REG_ONOFF: oldWord = {15'h0, onOffEn, offIn, onIn};
         `FSC_REG_ALARM: oldWord = {23'h0, alarmEn, tripIn};
         default: oldWord = 32'h0;
      endcase
   end

   wire [31:0] newWord;
   genvar gb;
   generate
      for (gb = 0; gb < 4; gb = gb + 1) begin : gByte
         assign newWord[8*gb+7:8*gb] = wStrbHold[gb] ? wDataHold[8*gb+7:8*gb] : oldWord[8*gb+7:8*gb];
      end
   endgenerate

   // ----------------------------------------
   // write legality checks
   // ----------------------------------------
   wire pctBad = (newWord[6:0] > `FSC_PCT_MAX) || (newWord[14:8] > `FSC_PCT_MAX)
      || (newWord[22:16] > `FSC_PCT_MAX);
   wire inBad = ($signed(newWord[7:0]) < $signed(newWord[15:8]))
      || (onOffEn && ($signed(onIn) > $signed(newWord[15:8])));
   wire onOffBad = newWord[`FSC_ONOFF_EN]
      && (($signed(newWord[7:0]) > $signed(idleIn))
      || ($signed(newWord[15:8]) >= $signed(newWord[7:0])));

   reg wrErr;
   always @* begin
      case (awAddrHold)
         `FSC_REG_CTRL: wrErr = 1'b0;
         `FSC_REG_SPEED: wrErr = pctBad;
         `FSC_REG_INPUT: wrErr = inBad;
         `FSC_REG_ONOFF: wrErr = onOffBad;
         `FSC_REG_ALARM: wrErr = 1'b0;
         default: wrErr = 1'b1;
      endcase
   end

   // ----------------------------------------
   // write channel and register updates
   // ----------------------------------------
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddrHold <= 8'h00;
         wDataHold <= 32'h0;
         wStrbHold <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `FSC_RESP_OKAY;
         commitReq <= 1'b0;
         pwmMode <= 1'b0;
         failIdle <= 1'b0;
         fullSpd <= `FSC_RST_FULLSPD;
         idleSpd <= `FSC_RST_IDLESPD;
         ovrSpd <= `FSC_RST_OVRSPD;
         fullIn <= `FSC_RST_FULLIN;
         idleIn <= `FSC_RST_IDLEIN;
         onIn <= 8'h00;
         offIn <= 8'h00;
         onOffEn <= 1'b0;
         tripIn <= `FSC_RST_TRIP;
         alarmEn <= 1'b1;
      end else begin
         commitReq <= 1'b0;
         if (awvalid && awready) begin
            awHeld <= 1'b1;
            awAddrHold <= awaddr;
         end
         if (wvalid && wready) begin
            wHeld <= 1'b1;
            wDataHold <= wdata;
            wStrbHold <= wstrb;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
         if (doWrite) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wrErr ? `FSC_RESP_SLVERR : `FSC_RESP_OKAY;
            if (!wrErr) begin
               // new settings steer the curve at once
               case (awAddrHold)
                  `FSC_REG_CTRL: begin
                     pwmMode <= newWord[`FSC_CTRL_PWM];
                     failIdle <= newWord[`FSC_CTRL_FAILIDLE];
                     commitReq <= wStrbHold[0] && wDataHold[`FSC_CTRL_COMMIT];
                  end
                  `FSC_REG_SPEED: begin
                     fullSpd <= newWord[6:0];
                     idleSpd <= newWord[14:8];
                     ovrSpd <= newWord[22:16];
                  end
                  `FSC_REG_INPUT: begin
                     fullIn <= newWord[7:0];
                     idleIn <= newWord[15:8];
                  end
                  `FSC_REG_ONOFF: begin
                     onIn <= newWord[7:0];
                     offIn <= newWord[15:8];
                     onOffEn <= newWord[`FSC_ONOFF_EN];
                  end
                  `FSC_REG_ALARM: begin
                     tripIn <= newWord[7:0];
                     alarmEn <= newWord[`FSC_ALARM_EN];
                  end
                  default: begin
                  end
               endcase
            end
         end
      end
   end

   // ----------------------------------------
   // read channel
   // ----------------------------------------
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= `FSC_RESP_OKAY;
      end else begin
         if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= `FSC_RESP_OKAY;
            case (araddr)
               `FSC_REG_CTRL: rdata <= {30'h0, failIdle, pwmMode};
               `FSC_REG_SPEED: rdata <= {9'h0, ovrSpd, 1'b0, idleSpd, 1'b0, fullSpd};
               `FSC_REG_INPUT: rdata <= {16'h0, idleIn, fullIn};
               `FSC_REG_ONOFF: rdata <= {15'h0, onOffEn, offIn, onIn};
               `FSC_REG_ALARM: rdata <= {23'h0, alarmEn, tripIn};
               `FSC_REG_STATUS: rdata <= {8'h0, ctrlValue, 5'h0, signalLost, motorOn, alarmOutput,
                  1'b0, driveLevel};
               default: begin
                  rdata <= 32'h0;
                  rresp <= `FSC_RESP_SLVERR;
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // control input selection
   // ----------------------------------------
   // running maximum over present sensors
   wire [8*NSENSE+7:0] maxChain;
   assign maxChain[7:0] = 8'h80;
   genvar gs;
   generate
      for (gs = 0; gs < NSENSE; gs = gs + 1) begin : gSense
         wire [7:0] t = controlInputHeader[8*gs+7:8*gs];
         wire [7:0] m = maxChain[8*gs+7:8*gs];
         assign maxChain[8*gs+15:8*gs+8] =
            (sensorPresent[gs] && ($signed(t) > $signed(m))) ? t : m;
      end
   endgenerate

   wire [7:0] hotTemp = maxChain[8*NSENSE+7:8*NSENSE];
   wire [7:0] lossIn = pwmMode ? `FSC_LOSS_DUTY : `FSC_LOSS_TEMP;
   wire [7:0] liveIn = pwmMode ? {1'b0, pwmInputTerminal} : hotTemp;
   wire [7:0] xIn = (signalLost && failIdle) ? lossIn : liveIn;
   wire lostFull = signalLost && !failIdle;

   // ----------------------------------------
   // alarm, hysteresis and curve
   // ----------------------------------------
   wire alarmNow = (alarmEn && ($signed(xIn) >= $signed(tripIn)))
      || (!pwmMode && sensorOpen);

   wire atOn = $signed(xIn) >= $signed(onIn);
   wire atOff = $signed(xIn) <= $signed(offIn);

   // linear segment between idle and full points
   wire signed [16:0] spdDelta = $signed({10'h0, fullSpd}) - $signed({10'h0, idleSpd});
   wire signed [16:0] inDelta = $signed({{9{xIn[7]}}, xIn}) - $signed({{9{idleIn[7]}}, idleIn});
   wire signed [16:0] span = $signed({{9{fullIn[7]}}, fullIn}) - $signed({{9{idleIn[7]}}, idleIn});
   wire signed [16:0] prod = spdDelta * inDelta;
   wire signed [16:0] span1 = (span == 17'sh0) ? 17'sh1 : span;
   wire signed [16:0] quot = prod / span1;
   wire signed [16:0] interp = $signed({10'h0, idleSpd}) + quot;

   reg [6:0] next_driveLevel;
   always @* begin
      if (overrideContactInput) begin
         next_driveLevel = ovrSpd;
      end else if (alarmNow || lostFull) begin
         next_driveLevel = fullSpd;
      end else if (onOffEn && !motorOn) begin
         next_driveLevel = 7'h00;
      end else if ($signed(xIn) >= $signed(fullIn)) begin
         next_driveLevel = fullSpd;
      end else if ($signed(xIn) <= $signed(idleIn)) begin
         next_driveLevel = idleSpd;
      end else begin
         next_driveLevel = interp[6:0];
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         motorOn <= 1'b1;
         driveLevel <= 7'h00;
         alarmOutput <= 1'b0;
         ctrlValue <= 8'h00;
      end else begin
         if (!onOffEn) begin
            motorOn <= 1'b1;
         end else if (motorOn && atOff) begin
            motorOn <= 1'b0;
         end else if (!motorOn && atOn) begin
            motorOn <= 1'b1;
         end
         driveLevel <= next_driveLevel;
         alarmOutput <= alarmNow;
         ctrlValue <= xIn;
      end
   end

endmodule

`default_nettype wire

// [testbench/fsc_speed_logic_monitor.sv]
// assertion monitor for the fan speed block
`timescale 1ns/100ps
`default_nettype none
module fsc_speed_logic_monitor (
   // clock, reset, bus
   input wire logic clk,
   input wire logic resetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   input wire logic rready,
   // fan side
   input wire logic overrideContactInput,
   input wire logic [6:0] driveLevel,
   input wire logic alarmOutput,
   input wire logic commitReq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   chk_override_hold:
      assert property ($past(overrideContactInput) && $past(overrideContactInput, 2) && !$past(bvalid)
         && !$past(bvalid, 2) |-> $stable(driveLevel)) else $error("drive moved under override");
   chk_alarm_full:
      assert property (alarmOutput && $past(alarmOutput) && !$past(overrideContactInput)
         && !$past(overrideContactInput, 2) && !$past(bvalid) && !$past(bvalid, 2) |-> $stable(driveLevel))
      else $error("drive moved in alarm");
   chk_drive_max:
      assert property (driveLevel <= 7'h64) else $error("drive above full scale");
   chk_commit_pulse:
      assert property (commitReq |=> !commitReq) else $error("commit pulse too long");
   chk_commit_cause:
      assert property (commitReq |-> bvalid || $past(bvalid)) else $error("commit without write");
   chk_bresp_hold:
      assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write answer dropped");
   chk_rdata_hold:
      assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read answer dropped");
   chk_wr_busy:
      assert property (bvalid |-> !awready && !wready) else $error("write taken while busy");
   chk_rd_busy:
      assert property (rvalid |-> !arready) else $error("read taken while busy");
   chk_rd_answer:
      assert property (arvalid && arready |=> rvalid) else $error("late read answer");
   chk_wr_answer:
      assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid) else $error("late write answer");
   cover property (overrideContactInput && alarmOutput);
   cover property (commitReq);
   cover property (bvalid && bresp == 2'h2);
endmodule
bind fsc_speed_logic fsc_speed_logic_monitor fsc_speed_logic_monitor_i (.clk, .resetn, .awvalid, .awready,
   .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
   .overrideContactInput, .driveLevel, .alarmOutput, .commitReq);
`default_nettype wire

// [testbench/fsc_programmer.sv]
// programmer model: register bus master
`timescale 1ns/100ps
`default_nettype none
module fsc_programmer (
   // clock and write channels
   input wire logic clk,
   output logic [7:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   // read channels
   output logic [7:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   localparam logic [7:0] REV = 8'h00; // supported revision, arbitrary; the block reads zero there
   int timeouts;
   // sixteen profiles of five settings words, each with a twelve-character label
   logic [31:0] profWord [0:15][0:4];
   logic [95:0] profLabel [0:15];
   initial begin
      {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
      wstrb = 4'hf;
   end
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      int n;
      @(posedge clk);
      awaddr <= a;
      wstrb <= s;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) begin
            wvalid <= 1'b0;
            wdata <= ~d;
         end
         if (bvalid) break;
      end
      bready <= 1'b0;
      r = bresp;
      if (n == 50) begin
         timeouts++;
         fsc_speed_logic_tb_top.stop_test();
      end
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      d = rdata;
      r = rresp;
      if (n == 50) begin
         timeouts++;
         fsc_speed_logic_tb_top.stop_test();
      end
   endtask
   // reports 0 good, 1 no valid data, 2 newer block, 3 older block
   task probe(input logic [7:0] a, output int verdict);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      if (r != 2'h0) begin
         verdict = 1;
      end else if (d[31:24] > REV) begin
         verdict = 2;
      end else if (d[31:24] < REV) begin
         verdict = 3;
      end else begin
         verdict = 0;
      end
   endtask
   // reads the five settings words into a labelled slot
   task save_profile(input int slot, input logic [95:0] label);
      logic [1:0] r;
      for (int i = 0; i < 5; i++) begin
         rd({i[5:0], 2'b00}, profWord[slot][i], r);
      end
      profLabel[slot] = label;
   endtask
   // copy: writes a stored slot to the connected block
   task write_profile(input int slot, output int errs);
      logic [1:0] r;
      errs = 0;
      for (int i = 0; i < 5; i++) begin
         wr({i[5:0], 2'b00}, profWord[slot][i], 4'hf, r);
         if (r != 2'h0) begin
            errs++;
         end
      end
   endtask
endmodule
`default_nettype wire

// [testbench/fsc_speed_logic_tb_top.sv]
// self-checking bench for the fan speed block
`timescale 1ns/100ps
`default_nettype none
module fsc_speed_logic_tb_top;
   logic clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rv;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rr;
   logic [23:0] controlInputHeader;
   logic [2:0] sensorPresent;
   logic [6:0] pwmInputTerminal, driveLevel;
   logic sensorOpen, signalLost, overrideContactInput, alarmOutput, commitReq;
   int fails, check_count, commits;
   fsc_speed_logic fsc_speed_logic_i (.clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .controlInputHeader(controlInputHeader),
      .sensorPresent(sensorPresent), .pwmInputTerminal(pwmInputTerminal), .sensorOpen(sensorOpen),
      .signalLost(signalLost), .overrideContactInput(overrideContactInput), .driveLevel(driveLevel),
      .alarmOutput(alarmOutput), .commitReq(commitReq));
   fsc_programmer fsc_programmer_i (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) if (commitReq === 1'b1) commits++;
   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task stop_test;
      fails += fsc_programmer_i.timeouts;
      $display("checks %0d errors %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // flags are override, lost, open
   task set(input logic [2:0] f, input logic [23:0] h, input logic [6:0] p, input logic [6:0] e, input logic a);
      @(posedge clk);
      {overrideContactInput, signalLost, sensorOpen} <= f;
      controlInputHeader <= h;
      pwmInputTerminal <= p;
      repeat (3) @(posedge clk);
      #1;
      chk({25'h0, driveLevel}, {25'h0, e});
      chk({31'h0, alarmOutput}, {31'h0, a});
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      fsc_programmer_i.wr(a, d, 4'hf, rr);
      chk({30'h0, rr}, {30'h0, e});
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      fsc_programmer_i.rd(a, rv, rr);
      chk(rv, e);
      chk({30'h0, rr}, {30'h0, er});
   endtask
   task t_regs;
      rd(8'h00, 32'h0, 2'h0);
      rd(8'h04, 32'h00643764, 2'h0);
      rd(8'h08, 32'h00002328, 2'h0);
      rd(8'h0c, 32'h0, 2'h0);
      rd(8'h10, 32'h00000132, 2'h0);
      rd(8'h20, 32'h0, 2'h2);
      wr(8'h20, 32'h0, 2'h2);
      wr(8'h14, 32'h0, 2'h2);
   endtask
   task t_temp;
      set(3'h0, 24'h0a250c, 7'h0, 7'h49, 1'b0);
      set(3'h0, 24'h23f0e7, 7'h0, 7'h37, 1'b0);
      set(3'h0, 24'h2800ff, 7'h0, 7'h64, 1'b0);
      set(3'h0, 24'h003200, 7'h0, 7'h64, 1'b1);
      set(3'h0, 24'h000a00, 7'h0, 7'h37, 1'b0);
      set(3'h1, 24'h000a00, 7'h0, 7'h64, 1'b1);
      @(posedge clk) sensorPresent <= 3'h5;
      set(3'h0, 24'h0a250c, 7'h0, 7'h37, 1'b0);
      @(posedge clk) sensorPresent <= 3'h7;
   endtask
   task t_pwm;
      wr(8'h00, 32'h1, 2'h0);
      wr(8'h04, 32'h00005014, 2'h0);
      wr(8'h04, 32'h00005065, 2'h2);
      wr(8'h08, 32'h00002320, 2'h2);
      set(3'h0, 24'h0, 7'h24, 7'h44, 1'b0);
      set(3'h0, 24'h0, 7'h28, 7'h14, 1'b0);
      set(3'h0, 24'h0, 7'h0a, 7'h50, 1'b0);
      set(3'h0, 24'h0, 7'h37, 7'h14, 1'b1);
      set(3'h4, 24'h0, 7'h3c, 7'h00, 1'b1);
      set(3'h0, 24'h0, 7'h1e, 7'h50, 1'b0);
      set(3'h1, 24'h0, 7'h1e, 7'h50, 1'b0);
      wr(8'h10, 32'h00000032, 2'h0);
      set(3'h0, 24'h0, 7'h37, 7'h14, 1'b0);
      wr(8'h10, 32'h00000132, 2'h0);
   endtask
   task t_loss;
      set(3'h2, 24'h0, 7'h1e, 7'h14, 1'b0);
      wr(8'h00, 32'h3, 2'h0);
      set(3'h2, 24'h0, 7'h3c, 7'h50, 1'b0);
      wr(8'h00, 32'h2, 2'h0);
      set(3'h2, 24'h3c3c3c, 7'h0, 7'h50, 1'b0);
      wr(8'h00, 32'h1, 2'h0);
   endtask
   task t_onoff;
      wr(8'h0c, 32'h0001141e, 2'h0);
      set(3'h0, 24'h0, 7'h0a, 7'h00, 1'b0);
      set(3'h0, 24'h0, 7'h19, 7'h00, 1'b0);
      set(3'h0, 24'h0, 7'h1e, 7'h50, 1'b0);
      set(3'h0, 24'h0, 7'h19, 7'h50, 1'b0);
      set(3'h0, 24'h0, 7'h14, 7'h00, 1'b0);
      rd(8'h14, 32'h00140000, 2'h0);
      wr(8'h0c, 32'h00011428, 2'h2);
      wr(8'h0c, 32'h00011e1e, 2'h2);
      wr(8'h08, 32'h00001928, 2'h2);
      rd(8'h0c, 32'h0001141e, 2'h0);
   endtask
   task t_commit;
      wr(8'h00, 32'h5, 2'h0);
      repeat (3) @(posedge clk);
      chk(commits, 32'h1);
      rd(8'h00, 32'h1, 2'h0);
   endtask
   task t_prog;
      int v;
      fsc_programmer_i.probe(8'h14, v);
      chk(v, 32'h0);
      fsc_programmer_i.probe(8'h18, v);
      chk(v, 32'h1);
      fsc_programmer_i.save_profile(3, "fan profile3");
      fsc_programmer_i.wr(8'h04, 32'h00630000, 4'h4, rr);
      chk({30'h0, rr}, 32'h0);
      rd(8'h04, 32'h00635014, 2'h0);
      fsc_programmer_i.write_profile(3, v);
      chk(v, 32'h0);
      rd(8'h04, 32'h00005014, 2'h0);
   endtask
   initial begin
      resetn = 1'b0;
      controlInputHeader = 24'h0;
      sensorPresent = 3'h7;
      pwmInputTerminal = 7'h0;
      {overrideContactInput, signalLost, sensorOpen} = 3'h0;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      t_regs();
      t_temp();
      t_pwm();
      t_loss();
      t_onoff();
      t_commit();
      t_prog();
      stop_test();
   end
endmodule
`default_nettype wire
